// *** src/nvh_host.sv ***
// Host controller driving the strobe, select, address and data pins of a
// 256x4 non-volatile RAM. Assumes the pins are wired directly to the part
// and that the data pins are a shared open-drain style bus.
`timescale 1ns/1ns
module nvh_host
   import nvh_pkg::*;
#(
   parameter int WR_TIMEOUT = WR_TIMEOUT_CYC
) (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              ce,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire nvh_req_t          req,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_rdata,
   output nvh_status_t            rsp_status,
   output logic                   busy,
   output logic                   address_strobe_n,
   output logic                   rw_sel,
   output logic [ADDR_W-1:0]      addr_out,
   output logic [DATA_W-1:0]      data_out,
   output logic [DATA_W-1:0]      data_oe_n,
   input  wire logic [DATA_W-1:0] data_in,
   input  wire logic              modify_done_flag
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_READ, ST_MOD_DLY, ST_MOD_LOW, ST_MOD_WAIT, ST_GAP
   } nvh_state_t;

   logic                    rst_m_ff;
   logic                    rst_s_ff;
   logic [DATA_W:0]         pin_sync;
   logic [DATA_W-1:0]       din_s;
   logic                    flag_s;

   nvh_state_t              state_ff,  nxt_state;
   logic [CNT_W-1:0]        cnt_ff,    nxt_cnt;
   nvh_pins_out_t           pins_ff,   nxt_pins;
   logic                    rsp_v_ff,  nxt_rsp_v;
   logic [DATA_W-1:0]       rdata_ff,  nxt_rdata;
   nvh_status_t             stat_ff,   nxt_stat;

   // Reset release through two flops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_m_ff <= 1'b0;
         rst_s_ff <= 1'b0;
      end else begin
         rst_m_ff <= 1'b1;
         rst_s_ff <= rst_m_ff;
      end
   end

   // Data bus and done flag come from the part's own timing
   nvh_sync #(.W(DATA_W + 1)) u_sync (
      .clk   (clk),
      .rst_n (rst_s_ff),
      .ce    (ce),
      .d     ({modify_done_flag, data_in}),
      .q     (pin_sync)
   );
   assign din_s  = pin_sync[DATA_W-1:0];
   assign flag_s = pin_sync[DATA_W];

   // Sequencer for read, modify and the strobe-high gap
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_pins  = pins_ff;
      nxt_rsp_v = 1'b0;
      nxt_rdata = rdata_ff;
      nxt_stat  = stat_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (req_valid) begin
               nxt_pins.as_n      = 1'b0;
               nxt_pins.addr      = req.addr;
               nxt_pins.dout      = req.wdata;
               nxt_pins.rw        = 1'b1;
               nxt_pins.dout_oe_n = {DATA_W{1'b1}};
               nxt_cnt            = '0;
               nxt_state          = req.modify ? ST_MOD_DLY : ST_READ;
            end
         end
         ST_READ: begin
            // Sample only once the access time has surely passed
            nxt_cnt = cnt_ff + 1'b1;
            if (cnt_ff == CNT_W'(ACC_CYC + 2)) begin
               nxt_rdata     = din_s;
               nxt_stat      = NVH_OK;
               nxt_rsp_v     = 1'b1;
               nxt_pins.as_n = 1'b1;
               nxt_cnt       = '0;
               nxt_state     = ST_GAP;
            end
         end
         ST_MOD_DLY: begin
            // Select falls inside the legal delay window, bus kept clear
            nxt_cnt = cnt_ff + 1'b1;
            if (cnt_ff == CNT_W'(D1_CYC - 1)) begin
               nxt_pins.rw        = 1'b0;
               nxt_pins.dout_oe_n = nxt_pins.dout;                // Open-drain: drive zeros only
               nxt_cnt            = '0;
               nxt_state          = ST_MOD_LOW;
            end
         end
         ST_MOD_LOW: begin
            nxt_cnt = cnt_ff + 1'b1;
            if (cnt_ff == CNT_W'(P_USE_CYC - 1)) begin
               nxt_pins.rw = 1'b1;
               nxt_pins.as_n = 1'b1;
               nxt_cnt     = '0;
               nxt_state   = ST_MOD_WAIT;
            end
         end
         ST_MOD_WAIT: begin
            // Part holds its own copy now, so the bus is released
            nxt_pins.dout_oe_n = {DATA_W{1'b1}};
            nxt_cnt = cnt_ff + 1'b1;
            if (cnt_ff > CNT_W'(4) && flag_s) begin
               nxt_stat  = NVH_OK;
               nxt_rsp_v = 1'b1;
               nxt_cnt   = '0;
               nxt_state = ST_GAP;
            end else if (cnt_ff == CNT_W'(WR_TIMEOUT)) begin
               nxt_stat  = NVH_TIMEOUT;
               nxt_rsp_v = 1'b1;
               nxt_cnt   = '0;
               nxt_state = ST_GAP;
            end
         end
         ST_GAP: begin
            nxt_cnt = cnt_ff + 1'b1;
            if (cnt_ff == CNT_W'(ASH_CYC - 1)) begin
               nxt_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_s_ff) begin
      if (!rst_s_ff) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= '0;
         pins_ff  <= '{as_n: 1'b1, rw: 1'b1, addr: '0, dout: '0, dout_oe_n: '1};
         rsp_v_ff <= 1'b0;
         rdata_ff <= '0;
         stat_ff  <= NVH_OK;
      end else if (ce) begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         pins_ff  <= nxt_pins;
         rsp_v_ff <= nxt_rsp_v;
         rdata_ff <= nxt_rdata;
         stat_ff  <= nxt_stat;
      end
   end

   // Pin and response outputs straight from flops; ready waits for the internal reset to end,
   // since a request taken while the sequencer is still held would be lost
   assign req_ready        = (state_ff == ST_IDLE) && ce && rst_s_ff;
   assign busy             = (state_ff != ST_IDLE);
   assign rsp_valid        = rsp_v_ff;
   assign rsp_rdata        = rdata_ff;
   assign rsp_status       = stat_ff;
   assign address_strobe_n = pins_ff.as_n;
   assign rw_sel           = pins_ff.rw;
   assign addr_out         = pins_ff.addr;
   assign data_out         = pins_ff.dout;
   assign data_oe_n        = pins_ff.dout_oe_n;
endmodule

// *** src/nvh_pkg.sv ***
// Package for the host-side controller of a 256x4 non-volatile RAM.
// Assumes a 50 MHz clock; all pin timing is counted in clk cycles.
package nvh_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 4;
   localparam int CLK_PERIOD_NS = 20;

   // Standard grade figures, the slower of the two, so both grades work
   localparam int T_ASL_NS = 700;
   localparam int T_ASH_NS = 300;
   localparam int T_D1_MIN_NS = 200;
   localparam int T_D1_MAX_NS = 600;
   localparam int T_P_NS = 300;
   localparam int T_ACC_NS = 700;
   localparam int T_WR_MAX_MS = 100;

   // Least times round up, longest times round down
   localparam int ASL_CYC = (T_ASL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ASH_CYC = (T_ASH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int D1_MIN_CYC = (T_D1_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int D1_MAX_CYC = T_D1_MAX_NS / CLK_PERIOD_NS;
   localparam int P_CYC = (T_P_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_TIMEOUT_CYC = T_WR_MAX_MS * 1000000 / CLK_PERIOD_NS;

   // Strobe-to-select delay chosen inside the legal window
   localparam int D1_CYC = D1_MIN_CYC;
   // Select low long enough for both its own minimum and the strobe minimum
   localparam int P_USE_CYC = (P_CYC > ASL_CYC - D1_CYC) ? P_CYC : ASL_CYC - D1_CYC;

   localparam int CNT_W = 23;

   typedef enum logic [1:0] {
      NVH_OK      = 2'h0,
      NVH_TIMEOUT = 2'h1
   } nvh_status_t;

   typedef struct packed {
      logic              modify;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } nvh_req_t;

   typedef struct packed {
      logic              as_n;
      logic              rw;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic [DATA_W-1:0] dout_oe_n;
   } nvh_pins_out_t;
endpackage

// *** src/nvh_sync.sv ***
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins change asynchronously to clk.
`timescale 1ns/1ns
module nvh_sync
   import nvh_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_sync;

   // First stage feeds only the second stage
   always_comb begin
      nxt_meta = ce ? d : meta_ff;
      nxt_sync = ce ? meta_ff : sync_ff;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign q = sync_ff;
endmodule

// *** verif/nvh_asserts.sv ***
// Checker for the host pins: strobe, select, data enable and handshake timing.
// Assumes ce stays high, so one clk cycle is one pin time step.
`timescale 1ns/1ns
module nvh_asserts
   import nvh_pkg::*;
(
   input wire logic              clk,
   input wire logic              arst_n,
   input wire logic              req_ready,
   input wire logic              rsp_valid,
   input wire logic              busy,
   input wire logic              address_strobe_n,
   input wire logic              rw_sel,
   input wire logic [DATA_W-1:0] data_oe_n,
   input wire logic              modify_done_flag
);
   logic [7:0] lo_ff;
   logic [7:0] hi_ff;
   logic [7:0] sl_ff;
   logic [7:0] fh_ff;

   // Saturating run length, zero when the level is absent
   function automatic logic [7:0] run(logic [7:0] c, logic lvl);
      return lvl ? ((c == 8'hFF) ? c : c + 8'h01) : 8'h00;
   endfunction

   // Run lengths of strobe low and high, select low and flag high; high runs start full after reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lo_ff <= 8'h00;
         hi_ff <= 8'hFF;
         sl_ff <= 8'h00;
         fh_ff <= 8'hFF;
      end else begin
         lo_ff <= run(lo_ff, !address_strobe_n);
         hi_ff <= run(hi_ff, address_strobe_n);
         sl_ff <= run(sl_ff, !rw_sel);
         fh_ff <= run(fh_ff, modify_done_flag);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   chk_strobe_low_min: assert property ($rose(address_strobe_n) |-> lo_ff >= ASL_CYC)
      else $error("strobe low time short");
   chk_strobe_high_min: assert property ($fell(address_strobe_n) |-> hi_ff >= ASH_CYC)
      else $error("strobe high time short");
   chk_sel_window: assert property ($fell(rw_sel) |-> lo_ff inside {[D1_MIN_CYC:D1_MAX_CYC]})
      else $error("select fell outside window");
   chk_sel_low_min: assert property ($rose(rw_sel) |-> sl_ff >= P_CYC && lo_ff >= ASL_CYC)
      else $error("select low time short");
   chk_read_access: assert property (rsp_valid && !$past(address_strobe_n) |-> lo_ff >= ACC_CYC)
      else $error("read data taken early");
   chk_flag_gap: assert property ($fell(address_strobe_n) |-> fh_ff >= ASH_CYC)
      else $error("strobe fell too soon after flag");
   chk_data_held: assert property (!rw_sel && !$past(rw_sel) |-> $stable(data_oe_n))
      else $error("write data moved while select low");
   chk_no_drive: assert property (rw_sel && $past(rw_sel) |-> &data_oe_n)
      else $error("data driven outside modify");
   chk_ready_idle: assert property (req_ready |-> !busy && address_strobe_n)
      else $error("ready while access open");
endmodule

bind nvh_host nvh_asserts i_chk (.clk(clk), .arst_n(arst_n), .req_ready(req_ready), .rsp_valid(rsp_valid),
   .busy(busy), .address_strobe_n(address_strobe_n), .rw_sel(rw_sel), .data_oe_n(data_oe_n),
   .modify_done_flag(modify_done_flag));

// *** verif/nvh_mem_model.sv ***
// Behavioural 256x4 non-volatile RAM answering the host by pin delays.
// Assumes open-drain data with pull-ups resolved by the bench.
`timescale 1ns/1ns
module nvh_mem_model
   import nvh_pkg::*;
(
   input  wire logic              as_n,
   input  wire logic              rw,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] dq,
   input  wire logic [1:0]        wmode,
   output logic [DATA_W-1:0]      pull,
   output logic                   flag
);
   logic [DATA_W-1:0] mem [256];
   logic [ADDR_W-1:0] a_lat;
   logic [DATA_W-1:0] d_lat;
   logic              pend;
   realtime           t_fall;

   // Contents start as a fixed pattern the bench knows
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = DATA_W'(i ^ (i >> 4));
      pull = '0;
      flag = 1'b1;
      pend = 1'b0;
   end

   // Access opens on strobe fall, no limit on how long it stays low
   always @(negedge as_n) begin
      if (flag) begin
         t_fall = $realtime;
         // Address moves with the strobe edge, so latch it a step later
         #1 a_lat = addr;
         #(T_ACC_NS - 1);
         if (!as_n && rw && flag) pull = ~mem[a_lat];
      end
   end

   always @(posedge as_n) pull = '0;

   // Early select changes are ignored
   always @(negedge rw) begin
      pull = '0;
      if (!as_n && flag && $realtime - t_fall >= T_D1_MIN_NS) pend = 1'b1;
   end

   // Word taken on select rise; slow modes stand in for an aged part
   always @(posedge rw) begin
      if (pend) begin
         pend = 1'b0;
         d_lat = dq;
         flag = 1'b0;
         #(wmode == 2'h0 ? 2000 : wmode == 2'h1 ? 20000 : 60000);
         mem[a_lat] = d_lat;
         flag = 1'b1;
      end
   end
endmodule

// *** verif/nvh_host_tb.sv ***
// Self-checking bench: host controller against the RAM model.
// Assumes pull-ups on the data bus and ce held high.
`timescale 1ns/1ns
module nvh_host_tb
   import nvh_pkg::*;
;
   logic              clk, arst_n, req_valid, req_ready, rsp_valid, busy, as_n, rw, flag;
   nvh_req_t          req;
   nvh_status_t       st, g_st;
   logic [DATA_W-1:0] rdata, g_rd, dout, oe_n, din, pull;
   logic [ADDR_W-1:0] addr;
   logic [1:0]        wmode;
   int                n_mismatch, n_compared, cyc;

   // Open drain: a bit is low when either side pulls it
   assign din = ~((~oe_n & ~dout) | pull);

   nvh_host #(.WR_TIMEOUT(2000)) i_nvh_host (.clk(clk), .arst_n(arst_n), .ce(1'b1), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rdata), .rsp_status(st),
      .busy(busy), .address_strobe_n(as_n), .rw_sel(rw), .addr_out(addr), .data_out(dout),
      .data_oe_n(oe_n), .data_in(din), .modify_done_flag(flag));
   nvh_mem_model i_nvh_mem_model (.as_n(as_n), .rw(rw), .addr(addr), .dq(din), .wmode(wmode),
      .pull(pull), .flag(flag));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic cmp4(string nm, logic [3:0] e, logic [3:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic cmp_st(string nm, nvh_status_t e, nvh_status_t g);
      cmp4(nm, {2'h0, e}, {2'h0, g});
   endtask

   // One request, held until taken, then the answer captured
   task automatic xfer(logic m, logic [7:0] a, logic [3:0] w);
      @(negedge clk);
      req = '{m, a, w};
      req_valid = 1'b1;
      while (req_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1) @(negedge clk);
      g_rd = rdata;
      g_st = st;
   endtask

   task automatic t_reset;
      cmp4("idle pins", 4'hF, {as_n, rw, &oe_n, flag});
      cmp4("busy ready", 4'h0, {2'h0, busy, req_ready});
   endtask

   task automatic t_read;
      logic [7:0] al [3] = '{8'h00, 8'hFF, 8'h5A};
      foreach (al[i]) begin
         xfer(1'b0, al[i], 4'h0);
         cmp4("read word", al[i][3:0] ^ al[i][7:4], g_rd);
      end
   endtask

   // Back-to-back modifies mixing program and erase, then read back
   task automatic t_modify;
      logic [11:0] wl [3] = '{12'h3C5, 12'hFFA, 12'h00F};
      foreach (wl[i]) xfer(1'b1, wl[i][11:4], wl[i][3:0]);
      foreach (wl[i]) begin
         xfer(1'b0, wl[i][11:4], 4'h0);
         cmp4("modified word", wl[i][3:0], g_rd);
      end
   endtask

   task automatic t_slow;
      wmode = 2'h1;
      xfer(1'b1, 8'h81, 4'h6);
      cmp_st("slow status", NVH_OK, g_st);
      xfer(1'b0, 8'h81, 4'h0);
      cmp4("slow word", 4'h6, g_rd);
   endtask

   // Part outlasts the host limit; wait out its flag before going on
   task automatic t_timeout;
      wmode = 2'h2;
      xfer(1'b1, 8'h42, 4'h9);
      cmp_st("timeout status", NVH_TIMEOUT, g_st);
      while (flag !== 1'b1) @(negedge clk);
      repeat (20) @(negedge clk);
      wmode = 2'h0;
      xfer(1'b0, 8'h42, 4'h0);
      cmp4("late word", 4'h9, g_rd);
   endtask

   task automatic close_out;
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Cycle ceiling well above the slowest modify path
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         close_out;
      end
   end

   initial begin
      arst_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      wmode = 2'h0;
      repeat (8) @(negedge clk);
      arst_n = 1'b1;
      t_reset;
      t_read;
      t_modify;
      t_slow;
      t_timeout;
      close_out;
   end
endmodule
